/* File: bttw_pkg.sv */
// constants, types and register map for the time-limit, trigger and wait command block
// assumes a 100 MHz clock and a host-side parser that turns text arguments into binary
//
// Operation
// RULE1: power-on limits ten seconds and one tenth second
// RULE2: limits run ten microseconds to one hour
// RULE3: zero limit disables that timeout entirely
// RULE4: late transfer aborted, aborted-operation error recorded
// RULE5: poll limit guards serial poll only, errors
// RULE6: query returns limits; out-of-range posts argument error
// RULE7: poll-only change leaves io limit alone
// RULE8: limits persist until reissued, online reset, power
// RULE9: trigger without addresses errors, triggers nothing
// RULE10: first controller command pulses clear, asserts remote
// RULE11: control passed away blocks command, not-controller error
// RULE12: wait returns status when masked event occurs
// RULE13: wait status format follows continuous reporting setting
// RULE14: wait mask bits follow status word layout
// RULE15: zero mask completes immediately with status
// RULE16: timeout bit ends wait within io limit
// RULE17: no timeout bit or zero limit: unbounded
// RULE18: wait without mask posts argument error
// RULE19: any notation converts to same mask bits
// RULE20: status bit fifteen flags any error
// RULE21: limits count in ten microsecond ticks
`default_nettype none

package bttw_pkg;

  // timing
  localparam int CLK_NS        = 10;
  localparam int TICK_NS       = 10_000;
  localparam int TICK_CYC      = TICK_NS / CLK_NS;
  localparam int DIV_W         = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
  localparam int TICKS_PER_S   = 1_000_000_000 / TICK_NS;
  localparam int IO_DEFAULT_S  = 10;
  localparam int SP_DEFAULT_MS = 100;
  localparam int LIMIT_MAX_S   = 3600;
  localparam int IFC_US        = 100;
  localparam logic [31:0] IO_DEFAULT_TICKS = 32'(IO_DEFAULT_S * TICKS_PER_S);
  localparam logic [31:0] SP_DEFAULT_TICKS = 32'(SP_DEFAULT_MS * TICKS_PER_S / 1000);
  localparam logic [31:0] LIMIT_MAX_TICKS  = 32'(LIMIT_MAX_S * TICKS_PER_S);
  localparam logic [31:0] IFC_TICKS = 32'((IFC_US * 1000 + TICK_NS - 1) / TICK_NS);

  // register byte offsets
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_IO_ARG    = 8'h04;
  localparam logic [7:0] REG_SP_ARG    = 8'h08;
  localparam logic [7:0] REG_WAIT_MASK = 8'h0C;
  localparam logic [7:0] REG_TRG_LIST  = 8'h10;
  localparam logic [7:0] REG_CONFIG    = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_ERROR     = 8'h1C;
  localparam logic [7:0] REG_RESULT    = 8'h20;
  localparam logic [7:0] REG_IO_LIMIT  = 8'h24;
  localparam logic [7:0] REG_SP_LIMIT  = 8'h28;

  // field positions
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OP_W     = 3;
  localparam int CMD_IO_BIT   = 4;
  localparam int CMD_SP_BIT   = 5;
  localparam int CMD_MASK_BIT = 6;
  localparam int CFG_NOSYS_BIT = 0;
  localparam int CFG_CONT_BIT  = 1;
  localparam int RES_FMT_BIT   = 16;
  localparam int RES_VALID_BIT = 17;
  localparam int RES_BUSY_BIT  = 18;
  localparam int ERR_SER_LSB   = 8;

  // status word bits
  localparam int ST_ERR  = 15;
  localparam int ST_TIMEOUT_FLAG = 14;
  localparam int ST_END  = 13;
  localparam int ST_SERVICE_REQUEST_FLAG = 12;
  localparam int ST_CMPL = 8;
  localparam int ST_LOK  = 7;
  localparam int ST_REM  = 6;
  localparam int ST_CIC  = 5;
  localparam int ST_ATN  = 4;
  localparam int ST_TACS = 3;
  localparam int ST_LACS = 2;
  localparam int ST_DTAS = 1;
  localparam int ST_DCAS = 0;
  localparam logic [15:0] WAIT_MASK_USED = 16'h70FF;

  // error codes
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_NOT_CIC  = 8'h01;
  localparam logic [7:0] ERR_ARG      = 8'h04;
  localparam logic [7:0] ERR_ABORTED  = 8'h06;

  typedef enum logic [2:0] {
    BTTW_OP_NONE  = 3'h0,
    BTTW_OP_TMO   = 3'h1,
    BTTW_OP_TRG   = 3'h2,
    BTTW_OP_WAIT  = 3'h3,
    BTTW_OP_ONL   = 3'h4
  } bttw_op_t;

  typedef enum logic [1:0] {BTTW_IDLE, BTTW_IFC, BTTW_TRIG, BTTW_WAIT} bttw_state_t;

  typedef struct packed {
    logic end_seen;
    logic srq;
    logic lockout_flag;
    logic rem;
    logic atn;
    logic tacs;
    logic lacs;
    logic dtas;
    logic dcas;
  } bttw_pins_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [31:0]      cnt;
    logic             fired;
  } bttw_guard_t;

  typedef struct packed {
    bttw_state_t  fsm;
    logic [9:0]   sync1;
    logic [9:0]   sync2;
    logic         lost_q;
    logic         cic;
    logic [31:0]  io_limit;
    logic [31:0]  sp_limit;
    logic [31:0]  io_arg;
    logic [31:0]  sp_arg;
    logic [15:0]  wait_mask;
    logic [31:0]  trg_list;
    logic         nosys;
    logic         cont;
    logic         timeout_flag;
    logic [7:0]   gpib_err;
    logic [15:0]  res_status;
    logic         res_fmt;
    logic         res_valid;
    bttw_guard_t  g_io;
    bttw_guard_t  g_sp;
    bttw_guard_t  g_wait;
    bttw_guard_t  g_ifc;
    logic [31:0]  rdata;
    logic         ifc;
    logic         ren;
    logic         trig_strobe;
    logic [31:0]  trig_out;
    logic         io_abort;
    logic         sp_fail;
    logic         wait_done;
  } bttw_regs_t;

endpackage : bttw_pkg

`default_nettype wire

/* File: bttw_cmd.sv */
// time-limit, trigger and wait command engine with its register port
// assumes a parser feeding binary arguments and engines reporting transfer activity
`default_nettype none

module bttw_cmd (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [31:0]        rdata,
  input  wire bttw_pkg::bttw_pins_t bus_pins,
  input  wire logic               cic_lost,
  input  wire logic               io_active,
  input  wire logic               sp_active,
  input  wire logic [7:0]         serial_err,
  output logic                    ifc,
  output logic                    ren,
  output logic                    trig_strobe,
  output logic      [31:0]        trig_list,
  output logic                    io_abort,
  output logic                    sp_fail,
  output logic                    wait_done
);

  bttw_pkg::bttw_regs_t st;
  bttw_pkg::bttw_regs_t next_st;

  // one step of a tick-based time guard; zero limit never fires
  function automatic bttw_pkg::bttw_guard_t guard_step(
    input logic                  active,
    input logic [31:0]           limit,
    input bttw_pkg::bttw_guard_t g
  );
    bttw_pkg::bttw_guard_t r;
    r = g;
    if (!active) begin
      r = '0;
    end else if (limit != '0 && !g.fired) begin // RULE3
      if (g.div == bttw_pkg::DIV_LAST) begin // RULE21
        r.div = '0;
        r.cnt = g.cnt + 32'h1;
        if (r.cnt >= limit) begin
          r.fired = 1'b1;
        end
      end else begin
        r.div = g.div + 10'h1;
      end
    end
    return r;
  endfunction

  // limits above one hour are refused
  function automatic logic arg_bad(input logic given, input logic [31:0] v);
    return given && (v > bttw_pkg::LIMIT_MAX_TICKS);
  endfunction

  bttw_pkg::bttw_pins_t pins_s;
  logic                 lost_s;
  logic [15:0]          status;
  logic                 take_cmd;
  bttw_pkg::bttw_op_t   op;
  logic                 has_io;
  logic                 has_sp;
  logic                 has_mask;
  logic                 io_exp;
  logic                 sp_exp;
  logic                 wait_exp;
  logic                 ifc_exp;
  logic [15:0]          timeout_flag_bit;

  always_comb begin
    next_st = st;
    next_st.rdata       = '0;
    next_st.trig_strobe = 1'b0;
    next_st.io_abort    = 1'b0;
    next_st.sp_fail     = 1'b0;
    next_st.wait_done   = 1'b0;

    // pin synchroniser
    next_st.sync1 = {cic_lost, bus_pins};
    next_st.sync2 = st.sync1;
    lost_s = st.sync2[9];
    pins_s = bttw_pkg::bttw_pins_t'(st.sync2[8:0]);

    // control passed away or regained
    next_st.lost_q = lost_s;
    if (lost_s) begin
      next_st.cic = 1'b0;
    end else if (st.lost_q) begin
      next_st.cic = 1'b1;
    end

    // live status word
    status = '0;
    status[bttw_pkg::ST_ERR]  = (st.gpib_err != bttw_pkg::ERR_NONE) ||
                                (serial_err != '0); // RULE20
    status[bttw_pkg::ST_TIMEOUT_FLAG] = st.timeout_flag;
    status[bttw_pkg::ST_END]  = pins_s.end_seen;
    status[bttw_pkg::ST_SERVICE_REQUEST_FLAG] = pins_s.srq && st.cic;
    status[bttw_pkg::ST_CMPL] = (st.fsm == bttw_pkg::BTTW_IDLE);
    status[bttw_pkg::ST_LOK]  = pins_s.lockout_flag; // RULE14
    status[bttw_pkg::ST_REM]  = pins_s.rem;
    status[bttw_pkg::ST_CIC]  = st.cic;
    status[bttw_pkg::ST_ATN]  = pins_s.atn;
    status[bttw_pkg::ST_TACS] = pins_s.tacs;
    status[bttw_pkg::ST_LACS] = pins_s.lacs;
    status[bttw_pkg::ST_DTAS] = pins_s.dtas;
    status[bttw_pkg::ST_DCAS] = pins_s.dcas;
    timeout_flag_bit = '0;
    timeout_flag_bit[bttw_pkg::ST_TIMEOUT_FLAG] = 1'b1;

    // register port
    take_cmd = wr && (addr == bttw_pkg::REG_CMD) && (st.fsm == bttw_pkg::BTTW_IDLE);
    op       = bttw_pkg::bttw_op_t'(wdata[bttw_pkg::CMD_OP_LSB +: bttw_pkg::CMD_OP_W]);
    has_io   = wdata[bttw_pkg::CMD_IO_BIT];
    has_sp   = wdata[bttw_pkg::CMD_SP_BIT];
    has_mask = wdata[bttw_pkg::CMD_MASK_BIT];
    if (wr) begin
      case (addr)
        bttw_pkg::REG_IO_ARG:    next_st.io_arg    = wdata;
        bttw_pkg::REG_SP_ARG:    next_st.sp_arg    = wdata;
        bttw_pkg::REG_WAIT_MASK: next_st.wait_mask = wdata[15:0]; // RULE19
        bttw_pkg::REG_TRG_LIST:  next_st.trg_list  = wdata;
        bttw_pkg::REG_CONFIG: begin
          next_st.nosys = wdata[bttw_pkg::CFG_NOSYS_BIT];
          next_st.cont  = wdata[bttw_pkg::CFG_CONT_BIT];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        bttw_pkg::REG_IO_ARG:    next_st.rdata = st.io_arg;
        bttw_pkg::REG_SP_ARG:    next_st.rdata = st.sp_arg;
        bttw_pkg::REG_WAIT_MASK: next_st.rdata = {16'h0000, st.wait_mask};
        bttw_pkg::REG_TRG_LIST:  next_st.rdata = st.trg_list;
        bttw_pkg::REG_CONFIG: begin
          next_st.rdata[bttw_pkg::CFG_NOSYS_BIT] = st.nosys;
          next_st.rdata[bttw_pkg::CFG_CONT_BIT]  = st.cont;
        end
        bttw_pkg::REG_STATUS:    next_st.rdata = {16'h0000, status};
        bttw_pkg::REG_ERROR: begin
          next_st.rdata[7:0] = st.gpib_err;
          next_st.rdata[bttw_pkg::ERR_SER_LSB +: 8] = serial_err;
        end
        bttw_pkg::REG_RESULT: begin
          next_st.rdata[15:0] = st.res_status;
          next_st.rdata[bttw_pkg::RES_FMT_BIT]   = st.res_fmt;
          next_st.rdata[bttw_pkg::RES_VALID_BIT] = st.res_valid;
          next_st.rdata[bttw_pkg::RES_BUSY_BIT]  = (st.fsm != bttw_pkg::BTTW_IDLE);
        end
        bttw_pkg::REG_IO_LIMIT:  next_st.rdata = st.io_limit; // RULE6
        bttw_pkg::REG_SP_LIMIT:  next_st.rdata = st.sp_limit;
        default:                 next_st.rdata = '0;
      endcase
    end

    // command acceptance; a new message clears the recorded error
    if (take_cmd) begin
      next_st.gpib_err  = bttw_pkg::ERR_NONE;
      next_st.timeout_flag      = 1'b0;
      next_st.res_valid = 1'b0;
      case (op)
        bttw_pkg::BTTW_OP_TMO: begin
          if (arg_bad(has_io, st.io_arg) || arg_bad(has_sp, st.sp_arg)) begin
            next_st.gpib_err = bttw_pkg::ERR_ARG; // RULE2 RULE6
          end else if (!has_io && !has_sp) begin
            next_st.res_valid = 1'b1; // RULE6
            next_st.res_fmt   = 1'b1;
          end else begin
            if (has_io) begin
              next_st.io_limit = st.io_arg; // RULE8
            end
            if (has_sp) begin
              next_st.sp_limit = st.sp_arg; // RULE7
            end
          end
        end
        bttw_pkg::BTTW_OP_TRG: begin
          if (st.trg_list == '0) begin
            next_st.gpib_err = bttw_pkg::ERR_ARG; // RULE9
          end else if (lost_s || (!st.cic && st.nosys)) begin
            next_st.gpib_err = bttw_pkg::ERR_NOT_CIC; // RULE11
          end else if (!st.cic) begin
            next_st.fsm = bttw_pkg::BTTW_IFC; // RULE10
            next_st.ifc = 1'b1;
            next_st.ren = 1'b1;
          end else begin
            next_st.fsm = bttw_pkg::BTTW_TRIG;
          end
        end
        bttw_pkg::BTTW_OP_WAIT: begin
          if (!has_mask) begin
            next_st.gpib_err = bttw_pkg::ERR_ARG; // RULE18
          end else if ((st.wait_mask & bttw_pkg::WAIT_MASK_USED) == '0) begin
            next_st.res_status = status; // RULE15
            next_st.res_fmt    = !st.cont;
            next_st.res_valid  = 1'b1;
            next_st.wait_done  = 1'b1;
          end else begin
            next_st.fsm = bttw_pkg::BTTW_WAIT;
          end
        end
        bttw_pkg::BTTW_OP_ONL: begin
          next_st.io_limit = bttw_pkg::IO_DEFAULT_TICKS; // RULE8
          next_st.sp_limit = bttw_pkg::SP_DEFAULT_TICKS;
          next_st.nosys    = 1'b0;
          next_st.cont     = 1'b0;
        end
        default: ;
      endcase
    end

    // time guards
    next_st.g_io = guard_step(io_active, st.io_limit, st.g_io);
    io_exp = next_st.g_io.fired && !st.g_io.fired;
    next_st.g_sp = guard_step(sp_active, st.sp_limit, st.g_sp); // RULE5
    sp_exp = next_st.g_sp.fired && !st.g_sp.fired;
    next_st.g_wait = guard_step((st.fsm == bttw_pkg::BTTW_WAIT) &&
                                st.wait_mask[bttw_pkg::ST_TIMEOUT_FLAG],
                                st.io_limit, st.g_wait); // RULE16 RULE17
    wait_exp = next_st.g_wait.fired && !st.g_wait.fired;
    next_st.g_ifc = guard_step(st.fsm == bttw_pkg::BTTW_IFC, bttw_pkg::IFC_TICKS, st.g_ifc);
    ifc_exp = next_st.g_ifc.fired && !st.g_ifc.fired;

    if (io_exp) begin
      next_st.io_abort = 1'b1; // RULE4
      next_st.gpib_err = bttw_pkg::ERR_ABORTED;
      next_st.timeout_flag     = 1'b1;
    end
    if (sp_exp) begin
      next_st.sp_fail  = 1'b1; // RULE5
      next_st.gpib_err = bttw_pkg::ERR_ABORTED;
    end

    case (st.fsm)
      bttw_pkg::BTTW_IDLE: ;
      bttw_pkg::BTTW_IFC: begin
        if (ifc_exp) begin
          next_st.ifc = 1'b0;
          next_st.cic = 1'b1;
          next_st.fsm = bttw_pkg::BTTW_TRIG;
        end
      end
      bttw_pkg::BTTW_TRIG: begin
        next_st.trig_strobe = 1'b1;
        next_st.trig_out    = st.trg_list;
        next_st.fsm         = bttw_pkg::BTTW_IDLE;
      end
      bttw_pkg::BTTW_WAIT: begin
        if ((status & st.wait_mask & bttw_pkg::WAIT_MASK_USED) != '0 || wait_exp) begin
          next_st.res_status = wait_exp ? (status | timeout_flag_bit) : status; // RULE12
          next_st.timeout_flag       = st.timeout_flag || wait_exp;
          next_st.res_fmt    = !st.cont; // RULE13
          next_st.res_valid  = 1'b1;
          next_st.wait_done  = 1'b1;
          next_st.fsm        = bttw_pkg::BTTW_IDLE;
        end
      end
      default: next_st.fsm = bttw_pkg::BTTW_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.fsm      <= bttw_pkg::BTTW_IDLE;
      st.io_limit <= bttw_pkg::IO_DEFAULT_TICKS; // RULE1
      st.sp_limit <= bttw_pkg::SP_DEFAULT_TICKS;
    end else begin
      st <= next_st;
    end
  end

  assign rdata       = st.rdata;
  assign ifc         = st.ifc;
  assign ren         = st.ren;
  assign trig_strobe = st.trig_strobe;
  assign trig_list   = st.trig_out;
  assign io_abort    = st.io_abort;
  assign sp_fail     = st.sp_fail;
  assign wait_done   = st.wait_done;

endmodule : bttw_cmd

`default_nettype wire

/* File: bttw_cmd_assertions.sv */
// port checks for the time-limit, trigger and wait command block, bound into bttw_cmd
// assumes one clock domain and the register map of bttw_pkg
`default_nettype none
module bttw_cmd_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        cic_lost,
  input wire logic        io_active,
  input wire logic        sp_active,
  input wire logic        ifc,
  input wire logic        ren,
  input wire logic        trig_strobe,
  input wire logic        io_abort,
  input wire logic        sp_fail,
  input wire logic        wait_done
);
  logic        lst_zero;
  logic [15:0] msk;
  logic [15:0] ifc_len;
  logic        cmd_wr;
  assign cmd_wr = wr && addr == bttw_pkg::REG_CMD;
  // shadows of the list and mask registers, length of clear pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lst_zero <= 1'b1;
      msk      <= 16'h0000;
      ifc_len  <= 16'h0000;
    end else begin
      if (wr && addr == bttw_pkg::REG_TRG_LIST) lst_zero <= wdata == 32'h0;
      if (wr && addr == bttw_pkg::REG_WAIT_MASK) msk <= wdata[15:0];
      ifc_len <= ifc ? ifc_len + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ifc_brings_ren: assert property ($rose(ifc) |-> ren)
    else $error("clear raised without remote enable");
  a_ifc_length: assert property ($fell(ifc) |->
    ifc_len >= 16'h270F && ifc_len <= 16'h2711) else $error("clear pulse length wrong");
  a_trig_after_ifc: assert property ($fell(ifc) |-> ##[0:2] trig_strobe)
    else $error("no trigger after clear");
  a_trg_empty: assert property (cmd_wr && wdata[2:0] == 3'h2 && lst_zero
    |=> (!trig_strobe && !ifc) [*4]) else $error("empty list acted on bus");
  a_not_cic: assert property (cmd_wr && wdata[2:0] == 3'h2 && cic_lost
    && $past(cic_lost, 4) |=> (!trig_strobe && !ifc) [*4]) else $error("trigger without control");
  a_mask_zero: assert property (cmd_wr && wdata[2:0] == 3'h3 && wdata[6]
    && (msk & 16'h70FF) == 16'h0000 |=> wait_done) else $error("empty mask did not finish");
  a_abort_in_io: assert property (io_abort |-> $past(io_active) ##1 !io_abort)
    else $error("abort outside transfer");
  a_poll_only: assert property (sp_fail |-> $past(sp_active) && !io_abort)
    else $error("poll failure outside poll");
endmodule // bttw_cmd_chk
bind bttw_cmd bttw_cmd_chk i_bttw_cmd_chk (.clk, .rst_n, .addr, .wdata, .wr, .cic_lost,
  .io_active, .sp_active, .ifc, .ren, .trig_strobe, .io_abort, .sp_fail, .wait_done);
`default_nettype wire

/* File: bttw_bus_model.sv */
// instrument and engine side: bus state lines, control loss, transfer and poll activity
// assumes the bench calls run and writes the lines; same clock as the block
`default_nettype none
module bttw_bus_model (
  input  wire logic                clk,
  input  wire logic                io_abort,
  input  wire logic                sp_fail,
  output var bttw_pkg::bttw_pins_t pins,
  output logic                     cic_lost,
  output logic                     io_active,
  output logic                     sp_active,
  output logic      [7:0]          serial_err
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {pins, cic_lost, io_active, sp_active, serial_err} = '0;
  // one transfer or poll; stops early when its guard fires
  task automatic run(input logic poll, input int cyc, output int len);
    len = 0;
    if (poll) sp_active <= 1'b1;
    else io_active <= 1'b1;
    do begin
      @(posedge clk);
      len++;
    end while (len < cyc && (poll ? sp_fail : io_abort) !== 1'b1);
    io_active <= 1'b0;
    sp_active <= 1'b0;
  endtask
endmodule // bttw_bus_model
`default_nettype wire

/* File: tb_bus_timeout_trigger_wait_cmds.sv */
// self-checking bench for the time-limit, trigger and wait command block
// assumes bttw_bus_model on the far side; io limit cut to three ticks
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_bus_timeout_trigger_wait_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } bttw_note_t;
  localparam int SB[9] = '{0, 1, 2, 3, 4, 6, 7, 12, 13};
  logic                 clk, rst_n, wr, rd, rd_d, ok, ifc, ren;
  logic                 cic_lost, io_active, sp_active, trig_strobe, io_abort, sp_fail, wait_done;
  logic [7:0]           addr, serial_err;
  logic [31:0]          wdata, rdata, trig_list, v;
  bttw_pkg::bttw_pins_t pins;
  bttw_note_t           q[$];
  int                   err_count, check_count, n, len, sp;
  bttw_cmd i_bttw_cmd (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .bus_pins(pins), .cic_lost,
    .io_active, .sp_active, .serial_err, .ifc, .ren, .trig_strobe, .trig_list, .io_abort,
    .sp_fail, .wait_done);
  bttw_bus_model i_bttw_bus_model (.clk, .io_abort, .sp_fail, .pins, .cic_lost, .io_active,
    .sp_active, .serial_err);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // read results are compared against the oldest note
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d === 1'b1) begin
      `CHK(rdata & q[0].m, q[0].e)
      void'(q.pop_front());
    end
  end
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e & m, m});
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [31:0] c);
    wreg(bttw_pkg::REG_CMD, c);
  endtask
  task automatic err(input logic [7:0] e);
    rreg(bttw_pkg::REG_ERROR, {24'h0, e}, 32'h000000FF);
  endtask
  task automatic lim(input logic [31:0] io, input logic [31:0] spl);
    rreg(bttw_pkg::REG_IO_LIMIT, io, '1);
    rreg(bttw_pkg::REG_SP_LIMIT, spl, '1);
  endtask
  function automatic logic hit(input int k);
    return (k == 0 ? wait_done : k == 1 ? trig_strobe : !ifc) === 1'b1;
  endfunction
  task automatic till(input int k, input int lmt);
    n  = 0;
    ok = hit(k);
    while (!ok && n < lmt) begin
      @(posedge clk);
      n++;
      ok = hit(k);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #600_000;
    err_count++;
    summarize();
  end
  initial begin
    {rst_n, wr, rd, addr, wdata} = '0;
    err_count   = 0;
    check_count = 0;
    void'($urandom(32'h8EB40AFF));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    lim(32'h000F4240, 32'h00002710);
    rreg(8'h30, 32'h0, '1);
    cmd(32'h1);
    rreg(bttw_pkg::REG_RESULT, 32'h00030000, 32'h00030000);
    wreg(bttw_pkg::REG_IO_ARG, 32'h15752A01 + ($urandom % 1000));
    cmd(32'h11);
    err(8'h04);
    sp = 1 + $urandom % 3;
    wreg(bttw_pkg::REG_SP_ARG, 32'(sp));
    cmd(32'h21);
    err(8'h00);
    lim(32'h000F4240, 32'(sp));
    wreg(bttw_pkg::REG_IO_ARG, 32'h15752A00);
    cmd(32'h11);
    lim(32'h15752A00, 32'(sp));
    wreg(bttw_pkg::REG_IO_ARG, 32'h3);
    cmd(32'h11);
    i_bttw_bus_model.run(1'b0, 5000, len);
    `CHK(1'(len >= 2998 && len <= 3004), 1'b1)
    err(8'h06);
    rreg(bttw_pkg::REG_STATUS, 32'hC000, 32'hC000);
    cmd(32'h1);
    i_bttw_bus_model.run(1'b1, 5000, len);
    `CHK(1'(len >= sp * 1000 - 2 && len <= sp * 1000 + 4), 1'b1)
    err(8'h06);
    wreg(bttw_pkg::REG_IO_ARG, 32'h0);
    cmd(32'h11);
    i_bttw_bus_model.run(1'b0, 4000, len);
    `CHK(len, 4000)
    wreg(bttw_pkg::REG_IO_ARG, 32'h3);
    cmd(32'h11);
    i_bttw_bus_model.run(1'b0, 1000, len);
    `CHK(len, 1000)
    wreg(bttw_pkg::REG_TRG_LIST, 32'h0);
    cmd(32'h2);
    err(8'h04);
    v = $urandom | 32'h1;
    wreg(bttw_pkg::REG_TRG_LIST, v);
    cmd(32'h2);
    `CHK({ifc, ren}, 2'b11)
    till(2, 10100);
    till(1, 4);
    `CHK(ok, 1'b1)
    `CHK(trig_list, v)
    i_bttw_bus_model.cic_lost <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(32'h2);
    err(8'h01);
    i_bttw_bus_model.cic_lost <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      wreg(bttw_pkg::REG_WAIT_MASK, 32'h1 << SB[i]);
      cmd(32'h43);
      rreg(bttw_pkg::REG_RESULT, 32'h00040000, 32'h00060000);
      i_bttw_bus_model.pins[i] <= 1'b1;
      till(0, 20);
      `CHK(ok, 1'b1)
      v = 32'h1 << SB[i];
      rreg(bttw_pkg::REG_RESULT, 32'h00020000 | v, 32'h00060000 | v);
      i_bttw_bus_model.pins[i] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    for (int j = 0; j < 3; j++) begin
      wreg(bttw_pkg::REG_CONFIG, j == 2 ? 32'h2 : 32'h0);
      wreg(bttw_pkg::REG_WAIT_MASK, j == 1 ? 32'h8F00 : 32'h0);
      cmd(32'h43);
      till(0, 0);
      `CHK(ok, 1'b1)
      rreg(bttw_pkg::REG_RESULT, j == 2 ? 32'h00020000 : 32'h00030000, 32'h00070000);
    end
    wreg(bttw_pkg::REG_CONFIG, 32'h0);
    wreg(bttw_pkg::REG_WAIT_MASK, 32'h4001);
    cmd(32'h43);
    till(0, 3100);
    `CHK(1'(ok && n >= 2990), 1'b1)
    rreg(bttw_pkg::REG_RESULT, 32'h00024000, 32'h00024001);
    wreg(bttw_pkg::REG_WAIT_MASK, 32'h0001);
    cmd(32'h43);
    till(0, 3500);
    `CHK(ok, 1'b0)
    i_bttw_bus_model.pins.dcas <= 1'b1;
    till(0, 20);
    `CHK(ok, 1'b1)
    i_bttw_bus_model.pins.dcas <= 1'b0;
    cmd(32'h3);
    err(8'h04);
    cmd(32'h1);
    v = 1 + $urandom % 4;
    i_bttw_bus_model.serial_err <= v[7:0];
    repeat (4) @(posedge clk);
    rreg(bttw_pkg::REG_STATUS, 32'h8000, 32'h8000);
    rreg(bttw_pkg::REG_ERROR, v << 8, 32'hFF00);
    i_bttw_bus_model.serial_err <= 8'h00;
    cmd(32'h4);
    lim(32'h000F4240, 32'h00002710);
    // second reset; system controller off leaves the block without control
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    lim(32'h000F4240, 32'h00002710);
    wreg(bttw_pkg::REG_CONFIG, 32'h1);
    wreg(bttw_pkg::REG_TRG_LIST, v | 32'h1);
    cmd(32'h2);
    `CHK({ifc, ren}, 2'b00)
    err(8'h01);
    summarize();
  end
endmodule // tb_bus_timeout_trigger_wait_cmds
`default_nettype wire
